// >>> core/mtdi_irq_top.sv
// timer and input-change interrupt controller with slave images, AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module mtdi_irq_top
  import mtdi_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic [11:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [11:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          scan_in_valid,
  input  wire logic [5:0]    scan_in_slave,
  input  wire logic [31:0]   scan_in_data,
  input  wire logic          scan_cycle_done,
  input  wire logic [5:0]    scan_out_slave,
  output logic [31:0]        scan_out_data,
  output logic               scan_hold,
  output logic               irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic        timer_en_ff, nxt_timer_en, di_en_ff, nxt_di_en;
  logic [1:0]  rtype_ff, nxt_rtype, status_ff, nxt_status, imask_ff, nxt_imask;
  logic [15:0] div_ff, nxt_div, tdown_ff, nxt_tdown;
  logic [7:0]  presc_ff, nxt_presc;
  logic [5:0]  sel_ff, nxt_sel;
  logic [4:0]  chan_ff, nxt_chan;
  logic [62:0] pol_in_ff, nxt_pol_in, pol_out_ff, nxt_pol_out;
  logic [15:0] watch_ff [0:62];
  logic [15:0] nxt_watch [0:62];
  logic [31:0] in_img_ff [0:62];
  logic [31:0] nxt_in_img [0:62];
  logic [31:0] out_img_ff [0:62];
  logic [31:0] nxt_out_img [0:62];
  logic        pend_ff, nxt_pend, hold_ff, nxt_hold;
  logic        aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata, scan_out_ff, nxt_scan_out;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

  logic        tick, pulse, hit, fire, set_di, clr_di, do_wr, do_rd, sel_ok;
  logic [5:0]  in_idx, sel_idx, out_idx;
  logic [31:0] bm, sel_in, rd_val;
  logic [1:0]  stat_clr;
  logic        rd_err, wr_err;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign in_idx  = scan_in_slave - 6'h01;
  assign sel_idx = sel_ff - 6'h01;
  assign out_idx = scan_out_slave - 6'h01;
  assign sel_ok  = (sel_ff != 6'h00);
  assign bm      = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign sel_in  = sel_ok ? (in_img_ff[sel_idx] ^ {32{pol_in_ff[sel_idx]}}) : 32'h00000000; // [R8] [R11] [R14]

  // ----------------------------------------
  // periodic timer
  // ----------------------------------------
  // counts aclk; the prescaler stands in for the base-clock division
  assign tick  = timer_en_ff && (presc_ff == PRESC_LAST); // [R1] [R16]
  assign pulse = tick && (tdown_ff == 16'h0000); // [R2] [R16]

  always_comb begin
    nxt_presc = timer_en_ff ? presc_ff + 8'h01 : 8'h00; // [R16]
    // holding the reload while disabled makes the first period a full one
    nxt_tdown = !timer_en_ff ? div_ff : (!tick ? tdown_ff : (pulse ? div_ff : tdown_ff - 16'h0001)); // [R1] [R16]
  end

  // ----------------------------------------
  // input-change detection
  // ----------------------------------------
  // only the low 16 channels are watchable, the mask is 16 bits wide
  assign hit  = scan_in_valid && (scan_in_slave != 6'h00) &&
                (|((scan_in_data[15:0] ^ in_img_ff[in_idx][15:0]) & watch_ff[in_idx])); // [R6]
  assign fire = (rtype_ff != RTYPE_IMM) && scan_cycle_done && (pend_ff || hit); // [R4]
  assign set_di = di_en_ff && ((rtype_ff == RTYPE_IMM) ? hit : fire); // [R3] [R4] [R7]

  always_comb begin
    nxt_pend = !scan_cycle_done && (pend_ff || (hit && (rtype_ff != RTYPE_IMM))); // [R4]
    // the hold drops with the change clear or as soon as type 3 is left
    nxt_hold = (set_di && (rtype_ff == RTYPE_HOLD)) || (hold_ff && !clr_di && (rtype_ff == RTYPE_HOLD)); // [R5] [R15]
    // a new event in the clearing cycle wins over the clear
    nxt_status = (status_ff & ~stat_clr) | {set_di, pulse}; // [R15]
  end
  assign clr_di = stat_clr[1];

  // ----------------------------------------
  // bus slave and register file
  // ----------------------------------------
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready  = !w_ok_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign do_rd = s_axi_arvalid && !rvalid_ff;
  assign stat_clr = (do_wr && awaddr_ff == STAT_OFS) ? (wdata_ff[1:0] & bm[1:0]) : 2'h0;

  always_comb begin
    rd_err = 1'b0;
    rd_val = 32'h00000000;
    if (s_axi_araddr[11:8] == IN_PAGE) begin
      rd_err = (s_axi_araddr[7:2] == 6'h3F);
      rd_val = rd_err ? 32'h00000000 : {16'h0000, in_img_ff[s_axi_araddr[7:2]][15:0]}; // [R12] [R13]
    end else if (s_axi_araddr[11:8] == OUT_PAGE) begin
      rd_err = (s_axi_araddr[7:2] == 6'h3F);
      rd_val = rd_err ? 32'h00000000 : {16'h0000, out_img_ff[s_axi_araddr[7:2]][15:0]}; // [R12] [R13]
    end else if (s_axi_araddr == CTRL_OFS) rd_val = {28'h0000000, rtype_ff, di_en_ff, timer_en_ff};
    else if (s_axi_araddr == DIV_OFS) rd_val = {16'h0000, div_ff};
    else if (s_axi_araddr == STAT_OFS) rd_val = {30'h0, status_ff};
    else if (s_axi_araddr == IMSK_OFS) rd_val = {30'h0, imask_ff};
    else if (s_axi_araddr == SEL_OFS) rd_val = {19'h00000, chan_ff, 2'h0, sel_ff};
    else if (s_axi_araddr == INW_OFS) rd_val = sel_in; // [R8]
    else if (s_axi_araddr == OUTW_OFS) rd_val = sel_ok ? out_img_ff[sel_idx] : 32'h00000000; // [R10]
    else if (s_axi_araddr == CHIN_OFS) rd_val = {31'h0, sel_in[chan_ff]}; // [R9]
    else if (s_axi_araddr == CHOUT_OFS) rd_val = {31'h0, sel_ok && out_img_ff[sel_idx][chan_ff]}; // [R9]
    else if (s_axi_araddr == POL_OFS) rd_val = sel_ok ? {30'h0, pol_out_ff[sel_idx], pol_in_ff[sel_idx]} : 32'h0;
    else if (s_axi_araddr == WATCH_OFS) rd_val = sel_ok ? {16'h0000, watch_ff[sel_idx]} : 32'h00000000;
    else rd_err = 1'b1;
  end

  always_comb begin
    nxt_aw_ok = aw_ok_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_ok = w_ok_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_timer_en = timer_en_ff;
    nxt_di_en = di_en_ff;
    nxt_rtype = rtype_ff;
    nxt_div = div_ff;
    nxt_imask = imask_ff;
    nxt_sel = sel_ff;
    nxt_chan = chan_ff;
    nxt_pol_in = pol_in_ff;
    nxt_pol_out = pol_out_ff;
    nxt_watch = watch_ff;
    nxt_in_img = in_img_ff;
    nxt_out_img = out_img_ff;
    wr_err = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_ok = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_ok = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (scan_in_valid && scan_in_slave != 6'h00) begin
      nxt_in_img[in_idx] = scan_in_data; // [R14]
    end
    if (do_wr) begin
      nxt_aw_ok = 1'b0;
      nxt_w_ok = 1'b0;
      nxt_bvalid = 1'b1;
      if (awaddr_ff[11:8] == IN_PAGE) begin
        wr_err = 1'b1;
      end else if (awaddr_ff[11:8] == OUT_PAGE) begin
        wr_err = (awaddr_ff[7:2] == 6'h3F);
        if (!wr_err) begin
          nxt_out_img[awaddr_ff[7:2]] = merge(out_img_ff[awaddr_ff[7:2]], wdata_ff, {16'h0000, bm[15:0]}); // [R12] [R13]
        end
      end else if (awaddr_ff == CTRL_OFS) begin
        if (wstrb_ff[0]) begin
          nxt_timer_en = wdata_ff[0]; // [R2]
          nxt_di_en = wdata_ff[1]; // [R7]
          // type 0 is not a valid type and leaves the old one
          if (wdata_ff[3:2] != 2'h0) begin
            nxt_rtype = wdata_ff[3:2];
          end
        end
      end else if (awaddr_ff == DIV_OFS) begin
        nxt_div = 16'(merge({16'h0000, div_ff}, wdata_ff, bm));
      end else if (awaddr_ff == STAT_OFS) begin
        wr_err = 1'b0;
      end else if (awaddr_ff == IMSK_OFS) begin
        nxt_imask = 2'(merge({30'h0, imask_ff}, wdata_ff, bm));
      end else if (awaddr_ff == SEL_OFS) begin
        if (wstrb_ff[0]) nxt_sel = wdata_ff[5:0];
        if (wstrb_ff[1]) nxt_chan = wdata_ff[12:8];
      end else if (awaddr_ff == OUTW_OFS) begin
        if (sel_ok) nxt_out_img[sel_idx] = merge(out_img_ff[sel_idx], wdata_ff, bm); // [R10]
      end else if (awaddr_ff == CHOUT_OFS) begin
        if (sel_ok && wstrb_ff[0]) nxt_out_img[sel_idx][chan_ff] = wdata_ff[0]; // [R9]
      end else if (awaddr_ff == POL_OFS) begin
        if (sel_ok && wstrb_ff[0]) begin
          nxt_pol_in[sel_idx] = wdata_ff[0]; // [R11]
          nxt_pol_out[sel_idx] = wdata_ff[1]; // [R11]
        end
      end else if (awaddr_ff == WATCH_OFS) begin
        if (sel_ok) nxt_watch[sel_idx] = 16'(merge({16'h0000, watch_ff[sel_idx]}, wdata_ff, bm)); // [R6]
      end else begin
        wr_err = 1'b1;
      end
      nxt_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_rd) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_val;
      nxt_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_scan_out = (scan_out_slave == 6'h00) ? 32'h00000000 :
                   (out_img_ff[out_idx] ^ {32{pol_out_ff[out_idx]}}); // [R11]
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_en_ff <= 1'b0;
      di_en_ff <= 1'b0;
      rtype_ff <= RTYPE_RST;
      div_ff <= DIV_RST;
      tdown_ff <= DIV_RST;
      presc_ff <= 8'h00;
      status_ff <= 2'h0;
      imask_ff <= 2'h0;
      sel_ff <= 6'h00;
      chan_ff <= 5'h00;
      pol_in_ff <= '0;
      pol_out_ff <= '0;
      watch_ff <= '{default: 16'h0000};
      in_img_ff <= '{default: 32'h00000000};
      out_img_ff <= '{default: 32'h00000000};
      pend_ff <= 1'b0;
      hold_ff <= 1'b0;
      aw_ok_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      w_ok_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
      scan_out_ff <= 32'h00000000;
    end else if (ce) begin
      timer_en_ff <= nxt_timer_en;
      di_en_ff <= nxt_di_en;
      rtype_ff <= nxt_rtype;
      div_ff <= nxt_div;
      tdown_ff <= nxt_tdown;
      presc_ff <= nxt_presc;
      status_ff <= nxt_status;
      imask_ff <= nxt_imask;
      sel_ff <= nxt_sel;
      chan_ff <= nxt_chan;
      pol_in_ff <= nxt_pol_in;
      pol_out_ff <= nxt_pol_out;
      watch_ff <= nxt_watch;
      in_img_ff <= nxt_in_img;
      out_img_ff <= nxt_out_img;
      pend_ff <= nxt_pend;
      hold_ff <= nxt_hold;
      aw_ok_ff <= nxt_aw_ok;
      awaddr_ff <= nxt_awaddr;
      w_ok_ff <= nxt_w_ok;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      scan_out_ff <= nxt_scan_out;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign scan_out_data = scan_out_ff;
  assign scan_hold = hold_ff; // [R5]
  assign irq = |(status_ff & imask_ff);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tmr_reload; ce && pulse |=> tdown_ff == $past(div_ff); endproperty
  a_tmr_reload: assert property (p_tmr_reload) else $error("timer did not reload"); // [R16]
  property p_tmr_presc; $rose(status_ff[0])
    |-> $past(presc_ff) == PRESC_LAST && $past(tdown_ff) == 16'h0000; endproperty
  a_tmr_presc: assert property (p_tmr_presc) else $error("timer flag off prescaler wrap"); // [R1]
  property p_tmr_off; ce && !timer_en_ff && !status_ff[0] |=> !status_ff[0]; endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("timer flag set while disabled"); // [R2]
  property p_t1; ce && di_en_ff && rtype_ff == RTYPE_IMM && hit |=> status_ff[1]; endproperty
  a_t1: assert property (p_t1) else $error("type 1 change not flagged"); // [R3]
  property p_t2; ce && di_en_ff && rtype_ff != RTYPE_IMM && !scan_cycle_done && !pend_ff && !status_ff[1]
    |=> !status_ff[1]; endproperty
  a_t2: assert property (p_t2) else $error("scan-end type flagged early"); // [R4]
  property p_hold; ce && set_di && rtype_ff == RTYPE_HOLD |=> scan_hold && status_ff[1]; endproperty
  a_hold: assert property (p_hold) else $error("type 3 did not hold scan"); // [R5]
  property p_hold_stat; scan_hold |-> status_ff[1]; endproperty
  a_hold_stat: assert property (p_hold_stat) else $error("hold without pending flag"); // [R15]
  property p_di_en; $rose(status_ff[1]) |-> $past(di_en_ff); endproperty
  a_di_en: assert property (p_di_en) else $error("change flag while disabled"); // [R7]
  property p_mask; ce && di_en_ff && rtype_ff == RTYPE_IMM && scan_in_valid && scan_in_slave != 6'h00 &&
    watch_ff[in_idx] == 16'h0000 && !status_ff[1] |=> !status_ff[1]; endproperty
  a_mask: assert property (p_mask) else $error("unwatched slave raised the change flag"); // [R6]
  c_timer: cover property (pulse);
  c_hold: cover property (scan_hold ##1 !scan_hold);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // mtdi_irq_top

// >>> core/mtdi_pkg.sv
// constants for the timer and input-change interrupt block
// What this block does
// (R1) the periodic rate is the base clock divided by 256 and then by the divisor plus one.
// (R2) the periodic interrupt is produced only while its enable bit is 1.
// (R3) in renewal type 1 the change interrupt fires as soon as a watched input bit toggles.
// (R4) in renewal type 2 the change interrupt fires at the end of a scan cycle that saw a toggle.
// (R5) in renewal type 3 it fires as in type 2 and then holds the scan until software clears it.
// (R6) each input slave has a watch mask and only masked bits can cause a change interrupt.
// (R7) a global enable gates the change interrupt; while it is clear no change event is signalled.
// (R8) the whole input state of the selected slave is read as one 32-bit word.
// (R9) a single channel of the selected slave can be read or written without touching the others.
// (R10) the last output word written to each slave is stored and returned on readback.
// (R11) each slave has its own input and output polarity bits applied to its inputs and outputs; the all-slave input block is read without input polarity.
// (R12) the low 16 bits of the input images of all slaves, and of the output images, are reachable as one block.
// (R13) in the all-slave block slave n sits at entry n minus one, for slaves 1 to 63.
// (R14) in a whole-module word channel k sits at bit k, channel 0 at bit 0.
// (R15) each source latches into a sticky pending bit; clearing the change bit releases a type 3 hold.
// (R16) the timer is a fixed divide-by-256 prescaler feeding a down-counter reloaded from the divisor.
package mtdi_pkg;
  localparam int         SLAVES       = 63;
  localparam int         AW           = 12;
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] DIV_OFS     = 12'h004;
  localparam logic [11:0] STAT_OFS    = 12'h008;
  localparam logic [11:0] IMSK_OFS    = 12'h00C;
  localparam logic [11:0] SEL_OFS     = 12'h010;
  localparam logic [11:0] INW_OFS     = 12'h014;
  localparam logic [11:0] OUTW_OFS    = 12'h018;
  localparam logic [11:0] CHIN_OFS    = 12'h01C;
  localparam logic [11:0] CHOUT_OFS   = 12'h020;
  localparam logic [11:0] POL_OFS     = 12'h024;
  localparam logic [11:0] WATCH_OFS   = 12'h028;
  localparam logic [3:0]  IN_PAGE     = 4'h1;
  localparam logic [3:0]  OUT_PAGE    = 4'h2;
  localparam logic [1:0]  RTYPE_RST   = 2'h1;
  localparam logic [1:0]  RTYPE_IMM   = 2'h1;
  localparam logic [1:0]  RTYPE_HOLD  = 2'h3;
  localparam logic [15:0] DIV_RST     = 16'h0000;
  localparam logic [7:0]  PRESC_LAST  = 8'hFF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// >>> tb/mtdi_scan_model.sv
// scan engine and remote input slaves seen from the block
`timescale 1ns/1ps
module mtdi_scan_model (
  input  wire logic        aclk,
  input  wire logic        scan_hold,
  input  wire logic [31:0] scan_out_data,
  output logic             scan_in_valid,
  output logic [5:0]       scan_in_slave,
  output logic [31:0]      scan_in_data,
  output logic             scan_cycle_done,
  output logic [5:0]       scan_out_slave
);
  // paused-scan waits that ran out, read by the bench at the end
  int stalls;
  initial begin
    stalls = 0;
    scan_in_valid   = 1'b0;
    scan_in_slave   = 6'h00;
    scan_in_data    = 32'h0000_0000;
    scan_cycle_done = 1'b0;
    scan_out_slave  = 6'h00;
  end
  // a paused scan sends nothing until released or until 500 cycles have passed
  task automatic wait_run();
    int n;
    @(negedge aclk);
    for (n = 0; n < 500 && scan_hold; n++) @(negedge aclk);
    if (scan_hold) stalls++;
    @(posedge aclk);
  endtask
  // channel k of the slave travels on bit k
  task automatic push(input logic [5:0] s, input logic [31:0] d);
    wait_run();
    scan_in_slave <= s;
    scan_in_data  <= d;
    scan_in_valid <= 1'b1;
    @(posedge aclk);
    scan_in_valid <= 1'b0;
    scan_in_data  <= ~d; // released bus, never the last word
  endtask
  task automatic end_cycle();
    wait_run();
    scan_cycle_done <= 1'b1;
    @(posedge aclk);
    scan_cycle_done <= 1'b0;
  endtask
  task automatic fetch(input logic [5:0] s, output logic [31:0] d);
    @(posedge aclk);
    scan_out_slave <= s;
    @(posedge aclk);
    @(negedge aclk);
    d = scan_out_data;
  endtask
endmodule // mtdi_scan_model

// >>> tb/master_timer_and_di_change_irq_tb.sv
// testbench for the timer and input-change interrupt block
`timescale 1ns/1ps
module master_timer_and_di_change_irq_tb;
  import mtdi_pkg::*;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        scan_in_valid, scan_cycle_done, scan_hold, irq, seen;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, scan_in_data, scan_out_data, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  scan_in_slave, scan_out_slave;
  int          mismatches, checks_done, n;
  mtdi_irq_top mtdi_irq_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .scan_in_valid, .scan_in_slave, .scan_in_data, .scan_cycle_done, .scan_out_slave,
    .scan_out_data, .scan_hold, .irq);
  mtdi_scan_model mtdi_scan_model_i (.aclk, .scan_hold, .scan_out_data, .scan_in_valid, .scan_in_slave,
    .scan_in_data, .scan_cycle_done, .scan_out_slave);
  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask
  task automatic stuck();
    mismatches++;
    finish_test();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, bd;
    bd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50 && !bd; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
    end
    if (!bd) stuck();
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, rd;
    rd = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50 && !rd; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rd = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rd) s_axi_rready <= 1'b0;
    end
    if (!rd) stuck();
    chk($sformatf("rdata %h", a), e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    rc(STAT_OFS, 32'h0000_0000, RESP_OKAY);
    rc(12'hFFC, 32'h0000_0000, RESP_SLVERR);
    // timer: 256 * (1 + 1) cycles from the enabling write
    wr(DIV_OFS, 32'h0000_0001, RESP_OKAY);
    wr(IMSK_OFS, 32'h0000_0001, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0005, RESP_OKAY);
    for (n = 0; n < 600 && irq !== 1'b1; n++) @(negedge aclk);
    chk("timer period", 32'h1, 32'(n >= 505 && n <= 515));
    rc(STAT_OFS, 32'h0000_0001, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    wr(STAT_OFS, 32'h0000_0001, RESP_OKAY);
    seen = 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(negedge aclk);
      if (irq !== 1'b0) seen = 1'b1;
    end
    chk("timer off irq", 32'h0, 32'(seen));
    // renewal type 1, watch bits 0 and 1 of slave 1
    wr(IMSK_OFS, 32'h0000_0002, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0006, RESP_OKAY);
    wr(SEL_OFS, 32'h0000_0001, RESP_OKAY);
    wr(WATCH_OFS, 32'h0000_0003, RESP_OKAY);
    mtdi_scan_model_i.push(6'h02, 32'h0000_FFFF);
    mtdi_scan_model_i.push(6'h01, 32'h0000_0004);
    rc(STAT_OFS, 32'h0000_0000, RESP_OKAY);
    mtdi_scan_model_i.push(6'h01, 32'h0000_0005);
    rc(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    rc(INW_OFS, 32'h0000_0005, RESP_OKAY);
    rc(CHIN_OFS, 32'h0000_0001, RESP_OKAY);
    wr(SEL_OFS, 32'h0000_0101, RESP_OKAY);
    rc(CHIN_OFS, 32'h0000_0000, RESP_OKAY);
    wr(INW_OFS, 32'h0000_0000, RESP_SLVERR);
    wr(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h0, 32'(irq));
    // type 2 waits for the end of the scan cycle
    wr(CTRL_OFS, 32'h0000_000A, RESP_OKAY);
    mtdi_scan_model_i.push(6'h01, 32'h0000_0004);
    rc(STAT_OFS, 32'h0000_0000, RESP_OKAY);
    mtdi_scan_model_i.end_cycle();
    rc(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    wr(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    // type 3 also holds the scan until cleared
    wr(CTRL_OFS, 32'h0000_000E, RESP_OKAY);
    mtdi_scan_model_i.push(6'h01, 32'h0000_0005);
    mtdi_scan_model_i.end_cycle();
    @(negedge aclk);
    chk("scan_hold", 32'h1, 32'(scan_hold));
    rc(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    wr(STAT_OFS, 32'h0000_0002, RESP_OKAY);
    @(negedge aclk);
    chk("scan_hold", 32'h0, 32'(scan_hold));
    // change enable cleared
    wr(CTRL_OFS, 32'h0000_000C, RESP_OKAY);
    mtdi_scan_model_i.push(6'h01, 32'h0000_0004);
    mtdi_scan_model_i.end_cycle();
    rc(STAT_OFS, 32'h0000_0000, RESP_OKAY);
    // outputs, channel write, polarity
    wr(SEL_OFS, 32'h0000_0301, RESP_OKAY);
    wr(OUTW_OFS, 32'hA5A5_1234, RESP_OKAY);
    rc(OUTW_OFS, 32'hA5A5_1234, RESP_OKAY);
    wr(CHOUT_OFS, 32'h0000_0001, RESP_OKAY);
    rc(OUTW_OFS, 32'hA5A5_123C, RESP_OKAY);
    wr(POL_OFS, 32'h0000_0003, RESP_OKAY);
    rc(INW_OFS, 32'hFFFF_FFFB, RESP_OKAY);
    rc(OUTW_OFS, 32'hA5A5_123C, RESP_OKAY);
    mtdi_scan_model_i.fetch(6'h01, d);
    chk("scan_out_data", 32'h5A5A_EDC3, d);
    wr(POL_OFS, 32'h0000_0000, RESP_OKAY);
    // all-slave images
    mtdi_scan_model_i.push(6'h3F, 32'h0001_2345);
    rc(12'h1F8, 32'h0000_2345, RESP_OKAY);
    rc(12'h100, 32'h0000_0004, RESP_OKAY);
    rc(12'h1FC, 32'h0000_0000, RESP_SLVERR);
    wr(12'h100, 32'h0000_0000, RESP_SLVERR);
    wr(12'h204, 32'h0000_BEEF, RESP_OKAY);
    wr(SEL_OFS, 32'h0000_0002, RESP_OKAY);
    rc(OUTW_OFS, 32'h0000_BEEF, RESP_OKAY);
    rc(DIV_OFS, 32'h0000_0001, RESP_OKAY);
    rc(IMSK_OFS, 32'h0000_0002, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    rc(CTRL_OFS, 32'h0000_000C, RESP_OKAY);
    chk("scan stalls", 32'h0, 32'(mtdi_scan_model_i.stalls));
    finish_test();
  end
endmodule // master_timer_and_di_change_irq_tb
